// *** hw/wasig_pkg.sv ***
// Package with register map, field codes and timing constants of the wind area signal block
package wasig_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets (Avalon-MM, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [5:0] OFF_CFG     = 6'h00; // Delays, activation, change/cycle
    localparam logic [5:0] OFF_LIM1    = 6'h04; // Limit one in degrees
    localparam logic [5:0] OFF_LIM2    = 6'h08; // Limit two in degrees
    localparam logic [5:0] OFF_EXTLIM  = 6'h0c; // Bus write of a limit (objects 63/79)
    localparam logic [5:0] OFF_MEAS    = 6'h10; // Direction and speed input
    localparam logic [5:0] OFF_STATUS  = 6'h14; // Area state, outputs
    localparam logic [5:0] OFF_TEXTSEL = 6'h18; // Text table index
    localparam logic [5:0] OFF_TEXTDAT = 6'h1c; // Text table byte

    // ------------------------------------------------------------------
    // Field positions inside CFG and EXTLIM
    // ------------------------------------------------------------------
    localparam int CFG_ON_LSB   = 0;  // 4 bits, switch-on delay code
    localparam int CFG_OFF_LSB  = 4;  // 4 bits, switch-off delay code
    localparam int CFG_ACT_LSB  = 8;  // 3 bits, activation combination
    localparam int CFG_CHG_BIT  = 11; // Send on change
    localparam int CFG_CYC_LSB  = 12; // 7 bits, cycle x 10 s
    localparam int CFG_HYS_LSB  = 20; // 6 bits, hysteresis degrees
    localparam int EXT_SEL_BIT  = 16; // 0 limit one (obj 63), 1 limit two (obj 79)
    localparam int EXT_FMT_LSB  = 17; // 2 bits, value format

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [31:0] CFG_RST  = 32'h00a0_0000; // Hysteresis 10 deg
    localparam logic [8:0]  LIM1_RST = 9'h05a;        // 90 deg
    localparam logic [8:0]  LIM2_RST = 9'h0b4;        // 180 deg
    localparam logic [8:0]  DEG_MAX  = 9'h168;        // 360 deg
    localparam logic [5:0]  HYS_MIN  = 6'h0a;         // 10 deg
    localparam logic [5:0]  HYS_MAX  = 6'h2d;         // 45 deg
    localparam logic [6:0]  CYC_MAX  = 7'h78;         // 120
    localparam logic [1:0]  FMT_F16  = 2'h0;          // Two-byte float
    localparam logic [1:0]  FMT_PCT  = 2'h1;          // One-byte percent
    localparam logic [1:0]  FMT_DEG  = 2'h2;          // One-byte degrees
    localparam int          SECTORS  = 16;
    localparam int          TEXT_LEN = 14;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ      = 50_000_000;
    localparam int TICK_S      = 1;
    localparam int TICK_CYC    = CLK_HZ * TICK_S;
    localparam int CYC_UNIT_S  = 10;

    // Change state machine states, one-hot encoded
    typedef enum logic [3:0] {
        WASIG_IDLE = 4'h1,
        WASIG_WAIT = 4'h2,
        WASIG_SEND = 4'h4,
        WASIG_HOLD = 4'h8
    } wasig_state_t;

endpackage

// *** hw/wasig_top.sv ***
// Wind area signal, direction byte and compass text outputs with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Rising area signal sent after switch-on delay
// - Falling area signal sent after switch-off delay
// - No delay sends value immediately on change
// - No-telegram activation never transmits that condition
// - Send-on-change transmits both transitions
// - Change sending off: cyclic still runs
// - Change off and cycle zero: never send
// - Cycle period is setting times ten seconds
// - Cycle setting zero disables repeats
// - Cyclic and change sends are independent
// - Direction byte output, north is zero
// - Zero wind speed forces direction zero
// - Fourteen-character text per compass sector
// - Area is one between limits one, two
// - Bus may write limits, objects 63, 79
// - Float limit outside 0..360 is ignored
// - Area clears only beyond limits plus hysteresis
// - Percent limit converts at 3.6 deg per percent
// - Activation combination picks ON, OFF or none
module wasig_top #(
    parameter int TICK_CYCLES = wasig_pkg::TICK_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             areaTxStb,
    output logic             areaTxVal,
    output logic             dirTxStb,
    output logic [7:0]       dirTxVal,
    output logic [111:0]     textTxVal
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Delay code to seconds: none,1,3,5,10,15,30,1m,3m,5m,10m,15m,30m,60m
    function automatic logic [11:0] delaySecs(input logic [3:0] code);
        case (code)
            4'h1:    delaySecs = 12'h001;
            4'h2:    delaySecs = 12'h003;
            4'h3:    delaySecs = 12'h005;
            4'h4:    delaySecs = 12'h00a;
            4'h5:    delaySecs = 12'h00f;
            4'h6:    delaySecs = 12'h01e;
            4'h7:    delaySecs = 12'h03c;
            4'h8:    delaySecs = 12'h0b4;
            4'h9:    delaySecs = 12'h12c;
            4'ha:    delaySecs = 12'h258;
            4'hb:    delaySecs = 12'h384;
            4'hc:    delaySecs = 12'h708;
            4'hd:    delaySecs = 12'he10;
            default: delaySecs = 12'h000;
        endcase
    endfunction

    // Activation: returns {inRange, under, exceed} codes, 0 OFF 1 ON 2 none
    function automatic logic [1:0] actCode(input logic [2:0] act, input logic [1:0] cond);
        logic [5:0] t;
        t = 6'h00;
        case (act)
            3'h0:    t = {2'h1, 2'h0, 2'h0};
            3'h1:    t = {2'h0, 2'h1, 2'h1};
            3'h2:    t = {2'h2, 2'h0, 2'h0};
            3'h3:    t = {2'h2, 2'h1, 2'h1};
            3'h4:    t = {2'h0, 2'h2, 2'h2};
            3'h5:    t = {2'h1, 2'h2, 2'h2};
            default: t = {2'h1, 2'h0, 2'h0};
        endcase
        case (cond)
            2'h0:    actCode = t[5:4];
            2'h1:    actCode = t[3:2];
            default: actCode = t[1:0];
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] cfg_q;
    logic [8:0]  lim1_q, lim2_q;
    logic [8:0]  dir_q;
    logic        speedZero_q;
    logic        measNew_q;
    logic [7:0]  textMem [wasig_pkg::SECTORS * wasig_pkg::TEXT_LEN];
    logic [7:0]  textSel_q;
    logic        ack_q;

    // Bus decode
    wire wrStb   = write && !ack_q;
    wire rdStb   = read && !ack_q;
    wire wrCfg   = wrStb && (address == wasig_pkg::OFF_CFG);
    wire wrLim1  = wrStb && (address == wasig_pkg::OFF_LIM1);
    wire wrLim2  = wrStb && (address == wasig_pkg::OFF_LIM2);
    wire wrExt   = wrStb && (address == wasig_pkg::OFF_EXTLIM);
    wire wrMeas  = wrStb && (address == wasig_pkg::OFF_MEAS);
    wire wrTSel  = wrStb && (address == wasig_pkg::OFF_TEXTSEL);
    wire wrTDat  = wrStb && (address == wasig_pkg::OFF_TEXTDAT);

    // Configuration fields
    wire [3:0] onCode  = cfg_q[wasig_pkg::CFG_ON_LSB +: 4];
    wire [3:0] offCode = cfg_q[wasig_pkg::CFG_OFF_LSB +: 4];
    wire [2:0] actSel  = cfg_q[wasig_pkg::CFG_ACT_LSB +: 3];
    wire       sendChg = cfg_q[wasig_pkg::CFG_CHG_BIT];
    wire [6:0] cycSet  = cfg_q[wasig_pkg::CFG_CYC_LSB +: 7];
    wire [5:0] hysRaw  = cfg_q[wasig_pkg::CFG_HYS_LSB +: 6];
    wire [5:0] hys     = (hysRaw < wasig_pkg::HYS_MIN) ? wasig_pkg::HYS_MIN :
                         (hysRaw > wasig_pkg::HYS_MAX) ? wasig_pkg::HYS_MAX : hysRaw;

    // External limit decode: float carries whole degrees in bits 15:0 here
    wire [1:0]  extFmt  = writedata[wasig_pkg::EXT_FMT_LSB +: 2];
    wire        extSel  = writedata[wasig_pkg::EXT_SEL_BIT];
    wire [15:0] pctDeg  = 16'((writedata[7:0] * 16'd36 + 16'd5) / 16'd10);
    wire [15:0] extDeg  = (extFmt == wasig_pkg::FMT_F16) ? writedata[15:0] :
                          (extFmt == wasig_pkg::FMT_PCT) ? pctDeg : {8'h00, writedata[7:0]};
    wire        extOk   = (extDeg <= 16'(wasig_pkg::DEG_MAX));

    // Register writes
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_q       <= wasig_pkg::CFG_RST;
            lim1_q      <= wasig_pkg::LIM1_RST;
            lim2_q      <= wasig_pkg::LIM2_RST;
            dir_q       <= 9'h000;
            speedZero_q <= 1'b1;
            measNew_q   <= 1'b0;
            textSel_q   <= 8'h00;
        end
        else
        begin
            measNew_q <= wrMeas;
            if (wrCfg) cfg_q <= writedata;
            if (wrLim1 || (wrExt && !extSel && extOk)) lim1_q <= wrLim1 ? writedata[8:0] : extDeg[8:0];
            if (wrLim2 || (wrExt && extSel && extOk)) lim2_q <= wrLim2 ? writedata[8:0] : extDeg[8:0];
            if (wrMeas)
            begin
                dir_q       <= (writedata[8:0] >= wasig_pkg::DEG_MAX) ? 9'h000 : writedata[8:0];
                speedZero_q <= (writedata[31:16] == 16'h0000);
            end
            if (wrTSel) textSel_q <= writedata[7:0];
            else if (wrTDat) textSel_q <= textSel_q + 8'h01;
        end
    end

    // Text table store
    always_ff @(posedge ref_clk)
    begin
        if (wrTDat && textSel_q < 8'(wasig_pkg::SECTORS * wasig_pkg::TEXT_LEN))
            textMem[textSel_q] <= writedata[7:0];
    end

    // ------------------------------------------------------------------
    // Area evaluation with hysteresis
    // ------------------------------------------------------------------
    logic       area_q;
    wire [9:0]  effDir   = speedZero_q ? 10'h000 : {1'b0, dir_q};
    wire        inRange  = (effDir >= {1'b0, lim1_q}) && (effDir <= {1'b0, lim2_q});
    wire        under    = (effDir + {4'h0, hys}) < {1'b0, lim1_q};
    wire        exceed   = effDir > ({1'b0, lim2_q} + {4'h0, hys});
    wire        areaRaw  = inRange ? 1'b1 : ((under || exceed) ? 1'b0 : area_q);

    // ------------------------------------------------------------------
    // One-second tick and delay/cycle timers
    // ------------------------------------------------------------------
    logic [25:0] tickCnt_q;
    logic        tick_q;
    logic [11:0] dlyCnt_q;
    logic [10:0] cycCnt_q;
    logic        pub_q;
    wasig_pkg::wasig_state_t st_q, st_d;

    wire [11:0] dlySel   = areaRaw ? delaySecs(onCode) : delaySecs(offCode);
    wire        changed  = areaRaw != pub_q;
    wire        dlyDone  = (dlyCnt_q == 12'h000);
    wire [10:0] cycLen   = 11'(cycSet * wasig_pkg::CYC_UNIT_S);
    wire        cycFire  = (cycSet != 7'h00) && tick_q && (cycCnt_q <= 11'h001);
    wire [1:0]  condSel  = pub_q ? 2'h0 : (under ? 2'h1 : 2'h2);
    wire [1:0]  condCode = actCode(actSel, condSel);
    wire        sendOk   = condCode != 2'h2;

    // Tick generator
    always_ff @(posedge ref_clk)
    begin
        if (srst || tickCnt_q == 26'(TICK_CYCLES - 1))
            tickCnt_q <= 26'h0;
        else
            tickCnt_q <= tickCnt_q + 26'h1;
        tick_q <= !srst && (tickCnt_q == 26'(TICK_CYCLES - 1));
    end

    // Change state machine
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            wasig_pkg::WASIG_IDLE:
                if (changed)
                    st_d = (dlySel == 12'h000) ? wasig_pkg::WASIG_SEND : wasig_pkg::WASIG_WAIT;
            wasig_pkg::WASIG_WAIT:
                if (!changed) st_d = wasig_pkg::WASIG_IDLE;
                else if (dlyDone) st_d = wasig_pkg::WASIG_SEND;
            wasig_pkg::WASIG_SEND: st_d = wasig_pkg::WASIG_IDLE;
            default:               st_d = wasig_pkg::WASIG_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q     <= wasig_pkg::WASIG_IDLE;
            dlyCnt_q <= 12'h000;
            area_q   <= 1'b0;
            pub_q    <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            area_q <= areaRaw;
            if (st_q == wasig_pkg::WASIG_IDLE && changed) dlyCnt_q <= dlySel;
            else if (tick_q && !dlyDone) dlyCnt_q <= dlyCnt_q - 12'h001;
            if (st_d == wasig_pkg::WASIG_SEND) pub_q <= areaRaw;
        end
    end

    // Cycle timer runs alone, never restarted by change sends
    always_ff @(posedge ref_clk)
    begin
        if (srst || cycSet == 7'h00)
            cycCnt_q <= 11'h000;
        else if (tick_q)
            cycCnt_q <= (cycCnt_q <= 11'h001) ? cycLen : cycCnt_q - 11'h001;
    end

    // ------------------------------------------------------------------
    // Telegram outputs
    // ------------------------------------------------------------------
    wire chgSend = (st_q == wasig_pkg::WASIG_SEND) && sendChg;
    wire areaVal = (condCode == 2'h1);

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            areaTxStb <= 1'b0;
            areaTxVal <= 1'b0;
            dirTxStb  <= 1'b0;
            dirTxVal  <= 8'h00;
            textTxVal <= '0;
        end
        else
        begin
            areaTxStb <= (chgSend || cycFire) && sendOk;
            if ((chgSend || cycFire) && sendOk) areaTxVal <= areaVal;
            dirTxStb  <= measNew_q || cycFire;
            dirTxVal  <= 8'(effDir);
            for (int i = 0; i < wasig_pkg::TEXT_LEN; i++)
                textTxVal[i*8 +: 8] <= textMem[8'(effDir / 10'd23) * 8'(wasig_pkg::TEXT_LEN) + 8'(i)];
        end
    end

    // Avalon slave answer, one wait cycle per access
    always_ff @(posedge ref_clk)
    begin
        if (srst) ack_q <= 1'b0;
        else      ack_q <= (read || write) && !ack_q;
        if (srst) readdata <= 32'h0;
        else if (rdStb)
            case (address)
                wasig_pkg::OFF_CFG:    readdata <= cfg_q;
                wasig_pkg::OFF_LIM1:   readdata <= {23'h0, lim1_q};
                wasig_pkg::OFF_LIM2:   readdata <= {23'h0, lim2_q};
                wasig_pkg::OFF_MEAS:   readdata <= {22'h0, effDir};
                wasig_pkg::OFF_STATUS: readdata <= {24'h0, st_q, areaTxVal, pub_q, area_q, 1'b0};
                default:               readdata <= 32'h0;
            endcase
    end
    assign waitrequest = (read || write) && !ack_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_NODELAY: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == wasig_pkg::WASIG_IDLE && changed && dlySel == 12'h000)
        |=> st_q == wasig_pkg::WASIG_SEND)
        else $error("undelayed change not sent");
    // Judged from the activation table itself, not from the decode function
    AST_NOTELE: assert property (@(posedge ref_clk) disable iff (srst)
        (($past(pub_q) && ($past(actSel) == 3'h2 || $past(actSel) == 3'h3)) ||
         (!$past(pub_q) && ($past(actSel) == 3'h4 || $past(actSel) == 3'h5)))
        |-> !areaTxStb)
        else $error("no-telegram condition sent");
    AST_CANCEL: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == wasig_pkg::WASIG_WAIT && !changed) |=> st_q == wasig_pkg::WASIG_IDLE)
        else $error("pending send not cancelled");
    AST_SILENT: assert property (@(posedge ref_clk) disable iff (srst)
        (!sendChg && cycSet == 7'h00) |=> !areaTxStb) else $error("sent while disabled");
    AST_ZEROSPD: assert property (@(posedge ref_clk) disable iff (srst)
        speedZero_q |=> dirTxVal == 8'h00) else $error("direction not zero");
    AST_INRANGE: assert property (@(posedge ref_clk) disable iff (srst)
        inRange |=> area_q) else $error("area not set in range");
    AST_EXTBAD: assert property (@(posedge ref_clk) disable iff (srst)
        (wrExt && !extOk) |=> $stable(lim1_q) && $stable(lim2_q))
        else $error("bad limit taken");
    AST_DELAY: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == wasig_pkg::WASIG_WAIT && !dlyDone) |=> st_q != wasig_pkg::WASIG_SEND)
        else $error("sent before delay");
    COV_SEND: cover property (@(posedge ref_clk) areaTxStb && areaTxVal);
    COV_CANCEL: cover property (@(posedge ref_clk) st_q == wasig_pkg::WASIG_WAIT && !changed);
    COV_CYC: cover property (@(posedge ref_clk) cycFire);

endmodule

`default_nettype wire

// *** tb/wasig_knx_peer.sv ***
// Bus peer model that receives the area and direction telegrams
`timescale 1ns/1ps
`default_nettype none
module wasig_knx_peer (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       areaTxStb,
    input  wire logic       areaTxVal,
    input  wire logic       dirTxStb,
    input  wire logic [7:0] dirTxVal,
    output logic [15:0]     areaCnt,
    output logic            areaLast,
    output logic [15:0]     dirCnt,
    output logic [7:0]      dirLast
);
    // ------------------------------------------------------------
    // Telegram capture
    // ------------------------------------------------------------
    // Counts each telegram and keeps the last value received
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            areaCnt  <= 16'h0000;
            areaLast <= 1'b0;
            dirCnt   <= 16'h0000;
            dirLast  <= 8'h00;
        end
        else
        begin
            if (areaTxStb === 1'b1)
            begin
                areaCnt  <= areaCnt + 16'h0001;
                areaLast <= areaTxVal;
            end
            if (dirTxStb === 1'b1)
            begin
                dirCnt  <= dirCnt + 16'h0001;
                dirLast <= dirTxVal;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/wind_area_signal_output_test.sv ***
// Self-checking testbench of the wind area signal block
`timescale 1ns/1ps
`default_nettype none
module wind_area_signal_output_test;
    logic         ref_clk   = 1'b0;
    logic         srst      = 1'b1;
    logic [5:0]   address   = 6'h00;
    logic         read      = 1'b0;
    logic         write     = 1'b0;
    logic [31:0]  writedata = 32'h0;
    logic [31:0]  readdata;
    logic         waitrequest;
    logic         areaTxStb;
    logic         areaTxVal;
    logic         dirTxStb;
    logic [7:0]   dirTxVal;
    logic [111:0] textTxVal;
    logic [15:0]  areaCnt;
    logic         areaLast;
    logic [15:0]  dirCnt;
    logic [7:0]   dirLast;
    int           miscompares     = 0;
    int           samples_checked = 0;

    // ------------------------------------------------------------
    // Clock, design and bus peer
    // ------------------------------------------------------------
    always #10 ref_clk = ~ref_clk;

    wasig_top #(.TICK_CYCLES(10)) u_dut (.ref_clk(ref_clk), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .areaTxStb(areaTxStb), .areaTxVal(areaTxVal),
        .dirTxStb(dirTxStb), .dirTxVal(dirTxVal), .textTxVal(textTxVal));

    wasig_knx_peer u_peer (.ref_clk(ref_clk), .srst(srst), .areaTxStb(areaTxStb),
        .areaTxVal(areaTxVal), .dirTxStb(dirTxStb), .dirTxVal(dirTxVal),
        .areaCnt(areaCnt), .areaLast(areaLast), .dirCnt(dirCnt), .dirLast(dirLast));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        address   <= a;
        writedata <= d;
        read      <= rd;
        write     <= !rd;
        @(posedge ref_clk);
        for (n = 0; n < 20 && waitrequest !== 1'b0; n++)
            @(posedge ref_clk);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        chk(32'(n < 20), 32'h1, "bus answer");
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask

    task rchk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        chk(q, e, "register read");
    endtask

    // Moves the direction and counts area telegrams in two windows
    task step(input logic [8:0] dir, input int quiet, input int win, input int n, input logic v);
        logic [15:0] c;
        c = areaCnt;
        wr(wasig_pkg::OFF_MEAS, {16'h0001, 7'h00, dir});
        repeat (quiet) @(posedge ref_clk);
        chk(32'(areaCnt), 32'(c), "early area telegram");
        repeat (win) @(posedge ref_clk);
        chk(32'(areaCnt), 32'(c) + 32'(n), "area telegram count");
        if (n > 0)
            chk(32'(areaLast), 32'(v), "area value");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk({30'h0, areaTxVal, dirTxStb}, 32'h0, "outputs after reset");
        rchk(wasig_pkg::OFF_CFG, wasig_pkg::CFG_RST);
        rchk(wasig_pkg::OFF_LIM1, 32'(wasig_pkg::LIM1_RST));
        rchk(wasig_pkg::OFF_LIM2, 32'(wasig_pkg::LIM2_RST));
        rchk(6'h20, 32'h0);
    endtask

    task t_nodelay;
        wr(wasig_pkg::OFF_CFG, 32'h00a0_0800);
        step(9'd120, 0, 10, 1, 1'b1);
        step(9'd85, 0, 30, 0, 1'b0);
        step(9'd70, 0, 10, 1, 1'b0);
    endtask

    task t_delay;
        wr(wasig_pkg::OFF_CFG, 32'h00a0_0822);
        wr(wasig_pkg::OFF_MEAS, {16'h0001, 7'h00, 9'd120});
        step(9'd70, 0, 60, 0, 1'b0);
        step(9'd120, 15, 40, 1, 1'b1);
        step(9'd70, 15, 40, 1, 1'b0);
    endtask

    task t_act;
        wr(wasig_pkg::OFF_CFG, 32'h00a0_0a00);
        step(9'd120, 0, 30, 0, 1'b0);
        step(9'd70, 0, 10, 1, 1'b0);
        wr(wasig_pkg::OFF_CFG, 32'h00a0_0900);
        step(9'd120, 0, 10, 1, 1'b0);
        step(9'd70, 0, 10, 1, 1'b1);
    endtask

    task t_cyclic;
        logic [15:0] c;
        wr(wasig_pkg::OFF_CFG, 32'h00a0_1000);
        c = areaCnt;
        repeat (250) @(posedge ref_clk);
        chk(32'((areaCnt - c) inside {16'h2, 16'h3}), 32'h1, "cyclic count");
        step(9'd120, 0, 10, 0, 1'b0);
        wr(wasig_pkg::OFF_CFG, 32'h00a0_0000);
        c = areaCnt;
        repeat (250) @(posedge ref_clk);
        chk(32'(areaCnt), 32'(c), "no cyclic telegram");
        step(9'd70, 0, 20, 0, 1'b0);
    endtask

    task t_dir;
        logic [15:0] c;
        c = dirCnt;
        wr(wasig_pkg::OFF_MEAS, {16'h0005, 7'h00, 9'd200});
        repeat (5) @(posedge ref_clk);
        chk(32'(dirCnt), 32'(c) + 32'h1, "direction telegram");
        chk(32'(dirLast), 32'h0000_00c8, "direction value");
        wr(wasig_pkg::OFF_MEAS, {16'h0000, 7'h00, 9'd200});
        repeat (5) @(posedge ref_clk);
        chk(32'(dirLast), 32'h0, "direction at zero speed");
    endtask

    task t_text;
        int i;
        wr(wasig_pkg::OFF_TEXTSEL, 32'h0);
        for (i = 0; i < 2 * wasig_pkg::TEXT_LEN; i++)
            wr(wasig_pkg::OFF_TEXTDAT, 32'h41 + 32'(i));
        wr(wasig_pkg::OFF_MEAS, {16'h0001, 7'h00, 9'd10});
        repeat (4) @(posedge ref_clk);
        chk(32'(textTxVal[7:0]), 32'h41, "first text byte");
        chk(32'(textTxVal[111:104]), 32'h4e, "last text byte");
        wr(wasig_pkg::OFF_MEAS, {16'h0001, 7'h00, 9'd30});
        repeat (4) @(posedge ref_clk);
        chk(32'(textTxVal[7:0]), 32'h4f, "second sector first byte");
        chk(32'(textTxVal[111:104]), 32'h5c, "second sector last byte");
    endtask

    task t_ext;
        wr(wasig_pkg::OFF_EXTLIM, 32'h0000_0190);
        rchk(wasig_pkg::OFF_LIM1, 32'h0000_005a);
        wr(wasig_pkg::OFF_EXTLIM, 32'h0003_0019);
        rchk(wasig_pkg::OFF_LIM2, 32'h0000_005a);
        wr(wasig_pkg::OFF_EXTLIM, 32'h0004_0064);
        rchk(wasig_pkg::OFF_LIM1, 32'h0000_0064);
        wr(wasig_pkg::OFF_EXTLIM, 32'h0001_012c);
        rchk(wasig_pkg::OFF_LIM2, 32'h0000_012c);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_nodelay();
        t_delay();
        t_act();
        t_cyclic();
        t_dir();
        t_text();
        t_ext();
        finish_test();
    end

    // Cuts a hang short well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
